//--- bench/pdm_ctl_model.sv
// Model of the external bus controller that steps the port
`timescale 1ns/1ps
module pdm_ctl_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        dma_request_n,
    input  wire logic        portDataOeN,
    input  wire logic        lastCycleN,
    input  wire logic [15:0] rdWord,
    input  wire logic [3:0]  stallCycles,
    input  wire logic        parkAfter,
    output logic             addr_select_n,
    output logic             target_ready_n,
    output logic [15:0]      portDataIn
);
    typedef enum logic [1:0] {PC_IDLE, PC_GRANT, PC_RUN, PC_DONE} pdm_ctl_state_t;
    pdm_ctl_state_t stateFf;
    logic [3:0]     stallFf;

    // ====================
    // Controller sequence
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stateFf <= PC_IDLE;
            addr_select_n <= 1'h0;
            target_ready_n <= 1'h1;
            stallFf <= 4'h0;
        end
        else
        begin
            case (stateFf)
                PC_IDLE: if (!dma_request_n)
                begin
                    addr_select_n <= 1'h0;
                    target_ready_n <= 1'h0;
                    stallFf <= stallCycles;
                    stateFf <= PC_GRANT;
                end
                else
                    {addr_select_n, target_ready_n} <= 2'h1;
                PC_GRANT: if (!portDataOeN)
                begin
                    addr_select_n <= 1'h1;
                    target_ready_n <= (stallFf != 4'h0);
                    stateFf <= PC_RUN;
                end
                PC_RUN:
                begin
                    target_ready_n <= (stallFf > 4'h1);
                    if (stallFf != 4'h0)
                        stallFf <= stallFf - 4'h1;
                    if (!lastCycleN)
                    begin
                        addr_select_n <= !parkAfter;
                        target_ready_n <= parkAfter;
                        stateFf <= PC_DONE;
                    end
                end
                default: if (dma_request_n)
                    stateFf <= PC_IDLE;
            endcase
        end
    end

    // Released bus inverts its last word every cycle instead of holding it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            portDataIn <= 16'h0000;
        else if (stateFf == PC_RUN || stateFf == PC_GRANT)
            portDataIn <= rdWord;
        else
            portDataIn <= ~portDataIn;
    end
endmodule : pdm_ctl_model

//--- bench/pdm_port_master_props.sv
// Checker: pin-level timing relations of the port DMA bus master
`timescale 1ns/1ps
module pdm_port_master_props #(
    parameter int DATA_W      = pdm_pkg::ADDR_DATA_W,
    parameter int BURST_LEN_W = 6
) (
    input wire logic                     mclk,
    input wire logic                     rst_n,
    input wire logic                     addr_select_n,
    input wire logic                     target_ready_n,
    input wire logic [DATA_W-1:0]        portDataIn,
    input wire logic                     reqValid,
    input wire pdm_pkg::pdm_req_t        reqInfo,
    input wire logic [BURST_LEN_W-1:0]   burstLen,
    input wire logic [DATA_W-1:0]        wrData,
    input wire logic                     wrDataTaken,
    input wire logic [DATA_W-1:0]        rdData,
    input wire logic                     rdDataValid,
    input wire logic                     dma_request_n,
    input wire logic                     queue_request_n,
    input wire logic                     queue_burst_out,
    input wire logic [DATA_W-1:0]        port_addr_data,
    input wire logic                     portDataOeN,
    input wire logic                     initiator_ready_n,
    input wire logic                     lastCycleN,
    input wire logic                     read_not_write,
    input wire logic [pdm_pkg::AUX_W-1:0] port_aux_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // ====================
    // Assertions
    AST_RESET_RELEASED: assert property ($rose(rst_n) |->
        portDataOeN && initiator_ready_n && lastCycleN)
        else $error("bus not released after reset");
    // Six cycles cover sync latency
    AST_PARK_FLOATS: assert property ((!addr_select_n && target_ready_n)[*6] |->
        portDataOeN)
        else $error("bus driven while parked");
    AST_LAST_ONE: assert property (!lastCycleN |=> lastCycleN)
        else $error("last cycle not followed by clean up");
    AST_LAST_READY: assert property (!lastCycleN |-> !initiator_ready_n)
        else $error("initiator not ready in last cycle");
    AST_ALE_CONTEXT: assert property ($fell(port_aux_out[0]) |->
        !portDataOeN && !initiator_ready_n && $stable(port_addr_data))
        else $error("latch strobe fell outside address hold");
    AST_STROBE_INV: assert property (port_aux_out[1] == !read_not_write)
        else $error("read strobe not inverse of read line");
    AST_CS_STABLE: assert property (!initiator_ready_n &&
        $past(initiator_ready_n) == 1'b0 |-> $stable(port_aux_out[3:2]))
        else $error("chip-select bits moved in a transfer");
    AST_ADDR1_LEVELS: assert property ($fell(portDataOeN) && read_not_write |->
        initiator_ready_n && lastCycleN && port_aux_out[0])
        else $error("wrong levels entering address phase one");
    AST_READ_CAPTURE: assert property ($fell(lastCycleN) && read_not_write |->
        ##[0:4] rdDataValid)
        else $error("read word not delivered after last cycle");

    CV_READ: cover property ($fell(port_aux_out[0]));
    CV_BURST: cover property (wrDataTaken ##1 wrDataTaken);
    CV_PARK: cover property ((!addr_select_n && target_ready_n)[*6]);
endmodule : pdm_port_master_props

bind pdm_port_master pdm_port_master_props #(.DATA_W(DATA_W), .BURST_LEN_W(BURST_LEN_W)) u_props (
    .mclk(mclk), .rst_n(rst_n), .addr_select_n(addr_select_n),
    .target_ready_n(target_ready_n), .portDataIn(portDataIn), .reqValid(reqValid),
    .reqInfo(reqInfo), .burstLen(burstLen), .wrData(wrData), .wrDataTaken(wrDataTaken),
    .rdData(rdData), .rdDataValid(rdDataValid), .dma_request_n(dma_request_n),
    .queue_request_n(queue_request_n), .queue_burst_out(queue_burst_out),
    .port_addr_data(port_addr_data), .portDataOeN(portDataOeN),
    .initiator_ready_n(initiator_ready_n), .lastCycleN(lastCycleN),
    .read_not_write(read_not_write), .port_aux_out(port_aux_out)
);

//--- bench/pdm_port_master_test.sv
// Testbench: self-checking scenarios for the port DMA bus master
`timescale 1ns/1ps
module pdm_port_master_test;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              addr_select_n, target_ready_n, reqValid, wrDataTaken, rdDataValid;
    logic              dma_request_n, queue_request_n, queue_burst_out, portDataOeN;
    logic              initiator_ready_n, lastCycleN, read_not_write, parkAfter;
    logic [15:0]       portDataIn, wrData, rdData, port_addr_data, rdWord, rdCap;
    logic [15:0]       aleBus, startBus;
    logic [5:0]        burstLen;
    logic [3:0]        port_aux_out, aleAux, stallCycles;
    logic              aleQ, oeQ, startIrdy;
    pdm_pkg::pdm_req_t reqInfo;
    int                errors, total_checks, cyc, wrCnt, lastCnt, lastAt, aleAt;

    always #2.5 mclk = ~mclk;

    pdm_port_master dut (
        .mclk(mclk), .rst_n(rst_n), .addr_select_n(addr_select_n),
        .target_ready_n(target_ready_n), .portDataIn(portDataIn), .reqValid(reqValid),
        .reqInfo(reqInfo), .burstLen(burstLen), .wrData(wrData), .wrDataTaken(wrDataTaken),
        .rdData(rdData), .rdDataValid(rdDataValid), .dma_request_n(dma_request_n),
        .queue_request_n(queue_request_n), .queue_burst_out(queue_burst_out),
        .port_addr_data(port_addr_data), .portDataOeN(portDataOeN),
        .initiator_ready_n(initiator_ready_n), .lastCycleN(lastCycleN),
        .read_not_write(read_not_write), .port_aux_out(port_aux_out)
    );

    pdm_ctl_model u_ctl (
        .mclk(mclk), .rst_n(rst_n), .dma_request_n(dma_request_n), .portDataOeN(portDataOeN),
        .lastCycleN(lastCycleN), .rdWord(rdWord), .stallCycles(stallCycles),
        .parkAfter(parkAfter), .addr_select_n(addr_select_n),
        .target_ready_n(target_ready_n), .portDataIn(portDataIn)
    );

    // ====================
    // Monitor and timeout
    always @(posedge mclk)
    begin
        if (wrDataTaken === 1'b1) begin wrCnt++; wrData <= wrData + 16'h0001; end
        if (rdDataValid === 1'b1) rdCap = rdData;
        if (lastCycleN === 1'b0) begin lastCnt++; lastAt = cyc; end
        if (aleQ === 1'b1 && port_aux_out[0] === 1'b0)
        begin
            aleAt = cyc;
            aleBus = port_addr_data;
            aleAux = port_aux_out;
        end
        if (oeQ === 1'b1 && portDataOeN === 1'b0)
        begin
            startBus = port_addr_data;
            startIrdy = initiator_ready_n;
        end
        aleQ = port_aux_out[0];
        oeQ = portDataOeN;
        cyc++;
    end

    always @(posedge mclk)
    begin
        if (cyc == 6000)
        begin
            errors++;
            final_report();
        end
    end

    // ====================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic xfer(input logic b, input logic [17:0] a, input logic [2:0] wc,
                        input logic [5:0] len);
        int n;
        wrCnt = 0;
        lastCnt = 0;
        rdCap = 16'h0000;
        reqInfo = '{burst: b, addr: a, waitCount: wc};
        burstLen = len;
        reqValid = 1'b1;
        n = 0;
        while (dma_request_n !== 1'b0 && n < 20) begin tick(1); n++; end
        reqValid = 1'b0;
        n = 0;
        while (!(lastCnt > 0 && dma_request_n === 1'b1 && portDataOeN === 1'b1) && n < 300)
        begin
            tick(1);
            n++;
        end
        tick(4);
    endtask : xfer

    // ====================
    // Scenarios
    task automatic test_reset;
        check(portDataOeN, 1'h1);
        check(initiator_ready_n, 1'h1);
        check(lastCycleN, 1'h1);
        check(port_aux_out, 4'h3);
        check(dma_request_n, 1'h1);
        check(queue_request_n, 1'h1);
        check(queue_burst_out, 1'h0);
        $display("test reset done");
    endtask : test_reset

    task automatic test_idle;
        int bad;
        bad = 0;
        repeat (40)
        begin
            tick(1);
            if (portDataOeN !== 1'b1 || dma_request_n !== 1'b1) bad++;
        end
        check(bad, 0);
        $display("test idle done");
    endtask : test_idle

    task automatic test_read_waits;
        int span0;
        int w;
        span0 = 0;
        for (w = 0; w < 8; w++)
        begin
            rdWord = 16'hC350 + w[15:0];
            xfer(1'b0, 18'h2A5C3, w[2:0], 6'h01);
            if (w == 0) span0 = lastAt - aleAt;
            check(lastAt - aleAt - span0, w);
            check(aleBus, 16'hA5C3);
            check(aleAux[3:2], 2'h2);
            check(aleAux[1], 1'h0);
            check(startIrdy, 1'h1);
            check(rdCap, rdWord);
            check(lastCnt, 1);
            check(portDataOeN, 1'h1);
        end
        $display("test read waits done");
    endtask : test_read_waits

    task automatic test_burst(input logic [5:0] len, input logic [3:0] stall);
        stallCycles = stall;
        xfer(1'b1, 18'h13F00, 3'h0, len);
        check(wrCnt, len);
        check(lastCnt, 1);
        check(startBus, 16'h3F00);
        check(startIrdy, 1'h1);
        check(portDataOeN, 1'h1);
        stallCycles = 4'h0;
        $display("test burst done");
    endtask : test_burst

    task automatic test_park;
        parkAfter = 1'b1;
        rdWord = 16'h9E61;
        xfer(1'b0, 18'h0F0F0, 3'h2, 6'h01);
        tick(10);
        check(portDataOeN, 1'h1);
        parkAfter = 1'b0;
        xfer(1'b0, 18'h30001, 3'h1, 6'h01);
        check(lastCnt, 1);
        check(rdCap, 16'h9E61);
        $display("test park done");
    endtask : test_park

    initial
    begin
        reqValid = 1'b0;
        reqInfo = '0;
        burstLen = 6'h01;
        wrData = 16'h1000;
        rdWord = 16'h0000;
        stallCycles = 4'h0;
        parkAfter = 1'b0;
        repeat (16) @(posedge mclk);
        #1;
        test_reset();
        rst_n = 1'b1;
        tick(4);
        test_idle();
        test_read_waits();
        test_burst(6'h04, 4'h0);
        test_burst(6'h01, 4'h0);
        test_burst(6'h3F, 4'h0);
        test_burst(6'h08, 4'h3);
        test_park();
        final_report();
    end
endmodule : pdm_port_master_test

//--- hw/pdm_pkg.sv
// Package: constants, states and carriers for the port DMA bus master
package pdm_pkg;

    // ==========================================================
    // Widths and field positions
    // ==========================================================
    localparam int ADDR_DATA_W  = 16;
    localparam int ADDR_W       = 18;
    localparam int WAIT_W       = 3;
    localparam int AUX_W        = 4;
    localparam int AUX_ALE_BIT  = 0;
    localparam int AUX_RDN_BIT  = 1;
    localparam int AUX_HI_LSB   = 2;
    localparam int ADDR_HI_LSB  = 16;
    // Wait-count field position in the request source word
    localparam int RSA_WAIT_LSB = 8;
    localparam int RSA_W        = 11;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic RST_INITIATOR_READY_N_N  = 1'b1;
    localparam logic RST_END_N   = 1'b1;
    localparam logic RST_ALE_N   = 1'b1;
    localparam logic RST_QBURST  = 1'b0;

    // ==========================================================
    // States (one-hot)
    // ==========================================================
    typedef enum logic [9:0] {
        ST_IDLE  = 10'h001,
        ST_ADDR  = 10'h002,  // burst address / non-burst address phase one
        ST_AD2   = 10'h004,
        ST_ADH   = 10'h008,
        ST_WRITE = 10'h010,
        ST_WAIT  = 10'h020,
        ST_LAST  = 10'h040,
        ST_CLEAN = 10'h080,
        ST_TRI   = 10'h100
    } pdm_state_t;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic                   burst;      // 1: burst write, 0: non-burst read
        logic [ADDR_W-1:0]      addr;
        logic [WAIT_W-1:0]      waitCount;
    } pdm_req_t;

    typedef struct packed {
        logic addrSelectN;
        logic targetReadyN;
    } pdm_ctl_t;

endpackage : pdm_pkg

//--- hw/pdm_port_master.sv
// Port DMA bus master: burst write and non-burst read state machine
// Function
// - 16-bit muxed bus, no halfword enables
// - Queue burst output; no register select
// - Idle held while no DMA request
// - Non-burst wait timer raises last_transfer_next
// - Chip-select bits valid Address1 through Clean Up
// - Read waits programmed count before sampling
// - Both low: go to Address 1
// - Address 1 to Address 2, ready low
// - Address 2 to Hold, latch strobe falls
// - Bus carries A15-0, aux carries A17-16
// - Aux bit 1 is inverted read line
// - Data Wait until timer, then Last
// - Last Transfer followed by Clean Up unless select is low (park or Address 1 wins)
// - Select low, ready high: park, float
// - Idle floats data, keeps control levels
// - Burst, both high: enter Data Wait
// - Burst, LAST_TRANSFER_NEXT low: enter Data Write
// - Burst, LAST_TRANSFER_NEXT high: enter Last Transfer
// - From parked Last/Clean: Write, not valid
`timescale 1ns/1ps
module pdm_port_master #(
    parameter int DATA_W = pdm_pkg::ADDR_DATA_W,
    parameter int BURST_LEN_W = 6
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       addr_select_n,
    input  wire logic                       target_ready_n,
    input  wire logic [DATA_W-1:0]          portDataIn,
    input  wire logic                       reqValid,
    input  wire pdm_pkg::pdm_req_t          reqInfo,
    input  wire logic [BURST_LEN_W-1:0]     burstLen,
    input  wire logic [DATA_W-1:0]          wrData,
    output logic                            wrDataTaken,
    output logic [DATA_W-1:0]               rdData,
    output logic                            rdDataValid,
    output logic                            dma_request_n,
    output logic                            queue_request_n,
    output logic                            queue_burst_out,
    output logic [DATA_W-1:0]               port_addr_data,
    output logic                            portDataOeN,
    output logic                            initiator_ready_n,
    output logic                            lastCycleN,
    output logic                            read_not_write,
    output logic [pdm_pkg::AUX_W-1:0]       port_aux_out
);
    // ==========================================================
    // Parameter check
    // ==========================================================
    initial
    begin
        if (DATA_W != 16)
            $error("pdm_port_master: DATA_W must be 16");
        if (BURST_LEN_W < 1)
            $error("pdm_port_master: BURST_LEN_W too small");
    end

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    pdm_pkg::pdm_ctl_t ctlSync;
    logic [DATA_W-1:0] dataSync;

    pdm_sync #(.WIDTH(2), .RST_VAL(2'h1)) u_ctlSync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   ({addr_select_n, target_ready_n}),
        .dout  (ctlSync)
    );

    pdm_sync #(.WIDTH(DATA_W), .RST_VAL('0)) u_dataSync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .din   (portDataIn),
        .dout  (dataSync)
    );

    logic aselN;
    logic trdyN;
    assign aselN = ctlSync.addrSelectN;
    assign trdyN = ctlSync.targetReadyN;

    // ==========================================================
    // Request capture
    // ==========================================================
    pdm_pkg::pdm_state_t state_ff;
    pdm_pkg::pdm_state_t nxt_state;
    pdm_pkg::pdm_state_t parked_ff;
    pdm_pkg::pdm_req_t   req_ff;
    logic                pending_ff;
    logic [BURST_LEN_W-1:0] remain_ff;
    logic                last_transfer_next;
    logic                timerExp;
    logic                enterAddr;

    assign enterAddr = (state_ff != pdm_pkg::ST_ADDR) && !aselN && !trdyN;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_ff <= 1'b0;
            req_ff     <= '0;
        end
        else if (reqValid && !pending_ff)
        begin
            pending_ff <= 1'b1;
            req_ff     <= reqInfo;
        end
        else if (nxt_state == pdm_pkg::ST_LAST && state_ff != pdm_pkg::ST_LAST)
            pending_ff <= 1'b0;
    end

    // ==========================================================
    // Last-transfer-next sources
    // ==========================================================
    // timer reloads on each address start
    pdm_wait_timer #(.WAIT_W(pdm_pkg::WAIT_W)) u_timer (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .load    (enterAddr),
        .loadVal (req_ff.waitCount),
        .run     (state_ff == pdm_pkg::ST_WAIT && !trdyN),
        .expired (timerExp)
    );

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            remain_ff <= '0;
        else if (enterAddr)
            remain_ff <= burstLen;
        else if (nxt_state == pdm_pkg::ST_WRITE && !trdyN && remain_ff != '0)
            remain_ff <= remain_ff - 1'b1;
    end

    // Burst ends by word count, non-burst by wait timer
    assign last_transfer_next = req_ff.burst ? (remain_ff <= 1) : timerExp;

    // ==========================================================
    // Next state
    // ==========================================================
    pdm_pkg::pdm_state_t from;
    always_comb
    begin
        from      = (state_ff == pdm_pkg::ST_TRI) ? parked_ff : state_ff;
        nxt_state = state_ff;
        if (aselN == 1'b0 && trdyN == 1'b1)
            nxt_state = pdm_pkg::ST_TRI;
        else if (aselN == 1'b0)
            nxt_state = pdm_pkg::ST_ADDR;
        else if (state_ff == pdm_pkg::ST_LAST)
            nxt_state = pdm_pkg::ST_CLEAN;
        else if (req_ff.burst)
        begin
            if (trdyN)
            begin
                if (state_ff != pdm_pkg::ST_IDLE && from != pdm_pkg::ST_AD2
                    && from != pdm_pkg::ST_ADH && from != pdm_pkg::ST_IDLE)
                    nxt_state = pdm_pkg::ST_WAIT;
            end
            else if (state_ff == pdm_pkg::ST_CLEAN)
                nxt_state = pdm_pkg::ST_IDLE;
            else if (state_ff == pdm_pkg::ST_TRI
                     && (from == pdm_pkg::ST_LAST || from == pdm_pkg::ST_CLEAN))
                nxt_state = pdm_pkg::ST_WRITE;
            else if (state_ff == pdm_pkg::ST_IDLE)
            begin
                if (pending_ff)
                    nxt_state = pdm_pkg::ST_WRITE;
            end
            else
                nxt_state = last_transfer_next ? pdm_pkg::ST_LAST : pdm_pkg::ST_WRITE;
        end
        else if (!trdyN)
        begin
            unique case (from)
                pdm_pkg::ST_ADDR:  nxt_state = pdm_pkg::ST_AD2;
                pdm_pkg::ST_AD2:   nxt_state = pdm_pkg::ST_ADH;
                pdm_pkg::ST_ADH:   nxt_state = pdm_pkg::ST_WAIT;
                pdm_pkg::ST_WAIT:  nxt_state = last_transfer_next ? pdm_pkg::ST_LAST : pdm_pkg::ST_WAIT;
                pdm_pkg::ST_CLEAN: nxt_state = pdm_pkg::ST_IDLE;
                default:           nxt_state = state_ff;
            endcase
        end
        else if (from == pdm_pkg::ST_WAIT)
            nxt_state = pdm_pkg::ST_WAIT;
    end

    // ==========================================================
    // State registers
    // ==========================================================
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff  <= pdm_pkg::ST_TRI;
            parked_ff <= pdm_pkg::ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state == pdm_pkg::ST_TRI && state_ff != pdm_pkg::ST_TRI)
                parked_ff <= state_ff;
        end
    end

    // ==========================================================
    // Bus outputs
    // ==========================================================
    logic drivingAddr;
    logic drivingData;
    assign drivingAddr = nxt_state inside {pdm_pkg::ST_ADDR, pdm_pkg::ST_AD2, pdm_pkg::ST_ADH}
                         && (req_ff.burst ? nxt_state == pdm_pkg::ST_ADDR : 1'b1);
    assign drivingData = req_ff.burst
                         && nxt_state inside {pdm_pkg::ST_WRITE, pdm_pkg::ST_WAIT,
                                              pdm_pkg::ST_LAST};

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_addr_data <= '0;
            portDataOeN    <= 1'b1;
        end
        else
        begin
            // low address bits on the bus
            if (drivingAddr)
                port_addr_data <= req_ff.addr[DATA_W-1:0];
            else if (drivingData)
                port_addr_data <= wrData;
            // data floats in Idle and parked
            portDataOeN <= !(drivingAddr || drivingData);
        end
    end

    // Outputs below hold their level while parked or idle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            initiator_ready_n <= pdm_pkg::RST_INITIATOR_READY_N_N;
            lastCycleN        <= pdm_pkg::RST_END_N;
        end
        else if (nxt_state != pdm_pkg::ST_TRI && nxt_state != pdm_pkg::ST_IDLE)
        begin
            // ready stays high after parked Last/Clean
            initiator_ready_n <= !(nxt_state inside {pdm_pkg::ST_AD2, pdm_pkg::ST_ADH,
                                    pdm_pkg::ST_LAST}
                                   || (nxt_state == pdm_pkg::ST_WRITE
                                       && !(state_ff == pdm_pkg::ST_TRI
                                            && from inside {pdm_pkg::ST_LAST,
                                                            pdm_pkg::ST_CLEAN}))
                                   || (nxt_state == pdm_pkg::ST_WAIT && !req_ff.burst
                                       && !trdyN));
            lastCycleN <= (nxt_state != pdm_pkg::ST_LAST);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            port_aux_out <= {2'h0, 1'b1, pdm_pkg::RST_ALE_N};
        else if (enterAddr)
            port_aux_out <= {req_ff.addr[pdm_pkg::ADDR_HI_LSB +: 2], req_ff.burst, 1'b1};
        // chip selects held through Clean Up
        // inverted read line on bit 1
        else if (nxt_state == pdm_pkg::ST_ADH)
            port_aux_out[pdm_pkg::AUX_ALE_BIT] <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            read_not_write <= 1'b0;
        else if (enterAddr)
            read_not_write <= !req_ff.burst;
    end

    // ==========================================================
    // Request lines and user side
    // ==========================================================
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dma_request_n   <= 1'b1;
            queue_request_n <= 1'b1;
            queue_burst_out <= pdm_pkg::RST_QBURST;
        end
        else
        begin
            dma_request_n   <= !pending_ff;
            queue_request_n <= !(reqValid || pending_ff);
            queue_burst_out <= pending_ff ? req_ff.burst : reqInfo.burst;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData      <= '0;
            rdDataValid <= 1'b0;
            wrDataTaken <= 1'b0;
        end
        else
        begin
            rdDataValid <= !req_ff.burst && nxt_state == pdm_pkg::ST_LAST
                           && state_ff != pdm_pkg::ST_LAST;
            if (!req_ff.burst && nxt_state == pdm_pkg::ST_LAST)
                rdData <= dataSync;
            wrDataTaken <= req_ff.burst && !trdyN
                           && nxt_state inside {pdm_pkg::ST_WRITE, pdm_pkg::ST_LAST};
        end
    end
endmodule : pdm_port_master

//--- hw/pdm_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module pdm_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1_ff;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_ff <= RST_VAL;
            dout      <= RST_VAL;
        end
        else
        begin
            stage1_ff <= din;
            dout      <= stage1_ff;
        end
    end
endmodule : pdm_sync

//--- hw/pdm_wait_timer.sv
// Programmable wait timer producing last_transfer_next
`timescale 1ns/1ps
module pdm_wait_timer #(
    parameter int WAIT_W = pdm_pkg::WAIT_W
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              load,
    input  wire logic [WAIT_W-1:0] loadVal,
    input  wire logic              run,
    output logic                   expired
);
    logic [WAIT_W-1:0] count_ff;

    initial
    begin
        if (WAIT_W < 1 || WAIT_W > 8)
            $error("pdm_wait_timer: WAIT_W out of range");
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            count_ff <= '0;
        else if (load)
            count_ff <= loadVal;
        else if (run && count_ff != '0)
            count_ff <= count_ff - 1'b1;
    end

    assign expired = run && (count_ff == '0);
endmodule : pdm_wait_timer
